// ===== udbg_pkg.sv
// constants shared by the debug serial port control block
// assumes an 8-bit special-function register port on the cpu clock
package udbg_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_ADDR = 8'h98;
  localparam logic [7:0] DATA_ADDR = 8'h99;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // control register fields
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int MPF_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TX9_BIT = 3;
  localparam int RX9_BIT = 2;
  localparam int TXF_BIT = 1;
  localparam int RXF_BIT = 0;

  // ==========================================================
  // modes, as {mode_select_high, mode_select_low}
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8BIT = 2'h1;
  localparam logic [1:0] MODE_9BIT_FIX = 2'h2;
  localparam logic [1:0] MODE_9BIT_VAR = 2'h3;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 100000000;
  localparam int MCYC_CLKS = 6;
  localparam int M0_RXF_MCYC = 9;
  localparam int M0_RXF_STATE = 1;
  localparam logic [6:0] M0_RXF_CLKS = 7'(MCYC_CLKS * M0_RXF_MCYC
    + M0_RXF_STATE);
  localparam logic [2:0] MCYC_LAST = 3'(MCYC_CLKS - 1);
  localparam logic [2:0] MCYC_HALF = 3'(MCYC_CLKS / 2);
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [2:0] M2_DIV_SLOW = 3'h3;
  localparam logic [2:0] M2_DIV_FAST = 3'h1;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] SYNC_BITS = 4'h8;

endpackage

// ===== udbg_tick.sv
// oversampling tick source for the asynchronous modes
// assumes ext_tick16 is a one-cycle pulse at sixteen times the bit rate
`timescale 1ns/1ps
`default_nettype none
module udbg_tick (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic rate_double,
  input wire logic ext_tick16,
  output logic tick16
);

  logic [2:0] div_q;
  logic [2:0] div_d;
  logic [2:0] div_last;
  logic tick16_q;
  logic tick16_d;
  logic fixed_rate;

  // fixed-rate 9-bit mode: bit = 32 or 64 clocks, so tick = 2 or 4 clocks
  assign fixed_rate = (mode == udbg_pkg::MODE_9BIT_FIX);
  assign div_last = rate_double ? udbg_pkg::M2_DIV_FAST
                                : udbg_pkg::M2_DIV_SLOW;
  assign div_d = (div_q >= div_last) ? 3'h0 : div_q + 3'h1;
  assign tick16_d = fixed_rate ? (div_q == div_last) : ext_tick16;
  assign tick16 = tick16_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_q <= 3'h0;
      tick16_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick16_q <= tick16_d;
    end
  end

endmodule
`default_nettype wire

// ===== udbg_serial_ctrl.sv
// debug serial port: control/status register, transmitter and receiver
// assumes sfr strobes are single-cycle and synchronous to ref_clk
//
// What this block does
// - top two control bits select mode
// - 9-bit filter drops frames with ninth bit zero
// - 8-bit filter drops frames without valid stop
// - reception starts only while receive enable is one
// - 9-bit modes send tx_ninth_bit as ninth
// - accepted frame stores ninth bit or stop bit
// - 9-bit modes set tx_done after ninth bit
// - other modes set tx_done after eighth bit
// - 9-bit rx_done one clock after ninth sample
// - 8-bit rx_done one clock after stop sample
// - shift mode rx_done at fixed delay after start
// - read-modify-write keeps hardware updates intact
// - data buffer write starts a transmission
// - start on start bit, or flag clear
// - async frame is start, data lsb first, stop; shift mode moves data only
`timescale 1ns/1ps
`default_nettype none
module udbg_serial_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rmw,
  output logic [7:0] sfr_rdata,
  input wire logic rate_double,
  input wire logic ext_tick16,
  output logic tx_pin,
  input wire logic rx_pin_i,
  output logic rx_pin_o,
  output logic rx_pin_oe
);

  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_ASYNC = 3'b010,
    TX_SYNC = 3'b100
  } udbg_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_ASYNC = 3'b010,
    RX_SYNC = 3'b100
  } udbg_rx_e;

  // ==========================================================
  // register bus decode
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] rxbuf_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic wr_ctrl;
  logic wr_data;
  logic [1:0] mode;
  logic nine_bit;

  assign wr_ctrl = sfr_wr && (sfr_addr == udbg_pkg::CTRL_ADDR);
  assign wr_data = sfr_wr && (sfr_addr == udbg_pkg::DATA_ADDR);
  assign mode = {ctrl_q[udbg_pkg::MODE_HI_BIT],
                 ctrl_q[udbg_pkg::MODE_LO_BIT]};
  assign nine_bit = mode[1];
  assign rdata_d = (sfr_addr == udbg_pkg::CTRL_ADDR) ? ctrl_q :
                   (sfr_addr == udbg_pkg::DATA_ADDR) ? rxbuf_q :
                   udbg_pkg::UNMAPPED_READ;

  // ==========================================================
  // tick sources
  logic tick16;
  logic [2:0] ph_q;
  logic ph_last;

  udbg_tick u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .mode(mode),
    .rate_double(rate_double),
    .ext_tick16(ext_tick16),
    .tick16(tick16)
  );

  // shared machine-cycle phase for shift mode, restarted per transfer
  assign ph_last = (ph_q == udbg_pkg::MCYC_LAST);

  // ==========================================================
  // transmitter
  udbg_tx_e tx_st_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_bit_q;
  logic [3:0] tx_ovs_q;
  logic [3:0] tx_nbits;
  logic [3:0] tx_flag_bit;
  logic tx_bit_end;
  logic tx_set;
  logic tx_ninth;

  // ninth data bit only goes out in the 9-bit modes
  assign tx_ninth = nine_bit ? ctrl_q[udbg_pkg::TX9_BIT] : 1'b1;
  assign tx_nbits = nine_bit ? udbg_pkg::FRAME_BITS_9
                             : udbg_pkg::FRAME_BITS_8;
  // async bit index 8 is the 8th data bit, 9 the 9th
  assign tx_flag_bit = nine_bit ? 4'h9 : 4'h8;
  assign tx_bit_end = (tx_st_q == TX_ASYNC) ? (tick16 &&
                      tx_ovs_q == udbg_pkg::OVS_LAST) :
                      (tx_st_q == TX_SYNC) && ph_last;
  assign tx_set = tx_bit_end && (((tx_st_q == TX_ASYNC) &&
                  tx_bit_q == tx_flag_bit) || ((tx_st_q == TX_SYNC) &&
                  tx_bit_q == 4'h7));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_bit_q <= 4'h0;
      tx_ovs_q <= 4'h0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (wr_data) begin
            tx_bit_q <= 4'h0;
            tx_ovs_q <= 4'h0;
            if (mode == udbg_pkg::MODE_SHIFT) begin
              tx_sh_q <= {3'h7, sfr_wdata};
              tx_st_q <= TX_SYNC;
            end else begin
              // start, data lsb first, optional ninth, stop
              tx_sh_q <= nine_bit ? {1'b1, tx_ninth, sfr_wdata, 1'b0}
                                  : {2'h3, sfr_wdata, 1'b0};
              tx_st_q <= TX_ASYNC;
            end
          end
        end
        TX_ASYNC: begin
          if (tick16) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
          end
          if (tx_bit_end) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == tx_nbits - 4'h1) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
        TX_SYNC: begin
          if (tx_bit_end) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == udbg_pkg::SYNC_BITS - 4'h1) begin
              tx_st_q <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_st_q <= TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // receiver
  udbg_rx_e rx_st_q;
  logic [8:0] rx_sh_q;
  logic [3:0] rx_bit_q;
  logic [3:0] rx_ovs_q;
  logic [6:0] rx_clk_q;
  logic rx_prev_q;
  logic rx_sample;
  logic rx_last;
  logic rx_ok;
  logic rx_acc_q;
  logic [7:0] rx_acc_data_q;
  logic rx_acc_ninth_q;
  logic rx_sync_start;
  logic rx_sync_set;
  logic rx_set;
  logic rx_ninth_set;

  // shift mode waits for flag clear and enable
  assign rx_sync_start = (mode == udbg_pkg::MODE_SHIFT) &&
                         ctrl_q[udbg_pkg::REN_BIT] &&
                         !ctrl_q[udbg_pkg::RXF_BIT] &&
                         (tx_st_q == TX_IDLE);
  assign rx_sample = (rx_st_q == RX_ASYNC) && tick16 &&
                     (rx_ovs_q == udbg_pkg::OVS_MID);
  // last sampled bit: ninth data bit, or stop bit in 8-bit mode
  assign rx_last = rx_sample && (rx_bit_q == 4'h9);
  assign rx_ok = !ctrl_q[udbg_pkg::MPF_BIT] || rx_pin_i;
  assign rx_sync_set = (rx_st_q == RX_SYNC) &&
                       (rx_clk_q == udbg_pkg::M0_RXF_CLKS);
  assign rx_set = rx_acc_q || rx_sync_set;
  assign rx_ninth_set = rx_acc_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= 9'h000;
      rx_bit_q <= 4'h0;
      rx_ovs_q <= 4'h0;
      rx_clk_q <= 7'h00;
      rx_prev_q <= 1'b1;
      rx_acc_q <= 1'b0;
      rx_acc_data_q <= 8'h00;
      rx_acc_ninth_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_pin_i;
      rx_acc_q <= 1'b0;
      case (rx_st_q)
        RX_IDLE: begin
          rx_bit_q <= 4'h0;
          rx_ovs_q <= 4'h0;
          rx_clk_q <= 7'h01;
          if (rx_sync_start) begin
            rx_st_q <= RX_SYNC;
          end else if (mode != udbg_pkg::MODE_SHIFT &&
                       ctrl_q[udbg_pkg::REN_BIT] &&
                       rx_prev_q && !rx_pin_i) begin
            rx_st_q <= RX_ASYNC;
          end
        end
        RX_ASYNC: begin
          if (tick16) begin
            rx_ovs_q <= rx_ovs_q + 4'h1;
          end
          if (!ctrl_q[udbg_pkg::REN_BIT]) begin
            rx_st_q <= RX_IDLE;
          end else if (rx_sample) begin
            rx_sh_q <= {rx_pin_i, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            // false start: line back high at mid start bit
            if (rx_bit_q == 4'h0 && rx_pin_i) begin
              rx_st_q <= RX_IDLE;
            end else if (rx_last) begin
              // accept pulse lands one clock after the sample
              rx_acc_q <= rx_ok;
              // data bits sit in the upper eight; this sample is not in yet
              rx_acc_data_q <= rx_sh_q[8:1];
              rx_acc_ninth_q <= rx_pin_i;
              rx_st_q <= RX_IDLE;
            end
          end
        end
        RX_SYNC: begin
          rx_clk_q <= rx_clk_q + 7'h01;
          if (ph_last && rx_bit_q < udbg_pkg::SYNC_BITS) begin
            rx_sh_q <= {rx_pin_i, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
          end
          if (rx_sync_set) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // control register, receive buffer and lock
  logic tx_pend_q;
  logic rx_pend_q;
  logic rx9_pend_q;
  logic rx9_pend_val_q;
  logic locked;
  logic [7:0] ctrl_wr;

  // while firmware holds a read-modify-write, hardware updates are
  // parked and merged into the write-back so they are not lost
  assign locked = sfr_rmw;
  assign ctrl_wr = wr_ctrl ? sfr_wdata : ctrl_q;

  always_comb begin
    ctrl_d = ctrl_wr;
    if (wr_ctrl && rx9_pend_q) begin
      ctrl_d[udbg_pkg::RX9_BIT] = rx9_pend_val_q;
    end
    if (rx_ninth_set) begin
      ctrl_d[udbg_pkg::RX9_BIT] = rx_acc_ninth_q;
    end
    // set wins over a same-cycle clearing write
    if (tx_set || (wr_ctrl && tx_pend_q)) begin
      ctrl_d[udbg_pkg::TXF_BIT] = 1'b1;
    end
    if (rx_set || (wr_ctrl && rx_pend_q)) begin
      ctrl_d[udbg_pkg::RXF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= udbg_pkg::CTRL_RESET;
      rxbuf_q <= udbg_pkg::DATA_RESET;
      rdata_q <= udbg_pkg::UNMAPPED_READ;
      tx_pend_q <= 1'b0;
      rx_pend_q <= 1'b0;
      rx9_pend_q <= 1'b0;
      rx9_pend_val_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      if (sfr_rd) begin
        rdata_q <= rdata_d;
      end
      if (rx_acc_q) begin
        rxbuf_q <= rx_acc_data_q;
      end else if (rx_sync_set) begin
        rxbuf_q <= rx_sh_q[8:1];
      end
      if (wr_ctrl || !locked) begin
        tx_pend_q <= 1'b0;
        rx_pend_q <= 1'b0;
        rx9_pend_q <= 1'b0;
      end
      if (locked && !wr_ctrl) begin
        if (tx_set) begin
          tx_pend_q <= 1'b1;
        end
        if (rx_set) begin
          rx_pend_q <= 1'b1;
        end
        if (rx_ninth_set) begin
          rx9_pend_q <= 1'b1;
          rx9_pend_val_q <= rx_acc_ninth_q;
        end
      end
    end
  end

  // ==========================================================
  // pins and shift-mode phase
  logic tx_pin_q;
  logic rx_pin_o_q;
  logic rx_pin_oe_q;
  logic sync_busy;

  assign sync_busy = (tx_st_q == TX_SYNC) || (rx_st_q == RX_SYNC);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ph_q <= 3'h0;
      tx_pin_q <= 1'b1;
      rx_pin_o_q <= 1'b1;
      rx_pin_oe_q <= 1'b0;
    end else begin
      ph_q <= (!sync_busy || ph_last) ? 3'h0 : ph_q + 3'h1;
      // shift mode: tx pin is the clock, low for the first half
      if (sync_busy && rx_bit_q < udbg_pkg::SYNC_BITS) begin
        tx_pin_q <= (ph_q >= udbg_pkg::MCYC_HALF);
      end else begin
        tx_pin_q <= (tx_st_q == TX_ASYNC) ? tx_sh_q[0] : 1'b1;
      end
      rx_pin_o_q <= tx_sh_q[0];
      rx_pin_oe_q <= (tx_st_q == TX_SYNC);
    end
  end

  assign tx_pin = tx_pin_q;
  assign rx_pin_o = rx_pin_o_q;
  assign rx_pin_oe = rx_pin_oe_q;
  assign sfr_rdata = rdata_q;

endmodule
`default_nettype wire

// ===== udbg_serial_ctrl_assertions.sv
// concurrent checks on the debug serial port control block
// assumes a bind to udbg_serial_ctrl; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module udbg_serial_ctrl_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_rdata,
  input wire logic rate_double,
  input wire logic ext_tick16,
  input wire logic tx_pin,
  input wire logic rx_pin_i,
  input wire logic rx_pin_o,
  input wire logic rx_pin_oe
);
  // ==========
  // helper state
  logic [1:0] mode_q;
  logic [1:0] seen_q;
  logic rdc_q;
  wire logic wrc = sfr_wr && sfr_addr == udbg_pkg::CTRL_ADDR;
  wire logic rdc = sfr_rd && sfr_addr == udbg_pkg::CTRL_ADDR;
  wire logic rdu = sfr_rd && sfr_addr != udbg_pkg::CTRL_ADDR
    && sfr_addr != udbg_pkg::DATA_ADDR;
  // mode bits are firmware-only, so a write shadow is exact
  always_ff @(posedge ref_clk) begin
    rdc_q <= !rst && rdc;
    if (rst)
      mode_q <= 2'h0;
    else if (wrc)
      mode_q <= sfr_wdata[7:6];
  end
  // flags seen high by a read; only a control write may drop them
  always_ff @(posedge ref_clk) begin
    if (rst || wrc)
      seen_q <= 2'h0;
    else if (rdc_q)
      seen_q <= sfr_rdata[1:0];
  end

  // ==========
  // assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  reset_state_a: assert property (
    $fell(rst) |-> tx_pin && rx_pin_o && !rx_pin_oe && sfr_rdata == 8'h00)
    else $error("outputs not at reset values");
  unmapped_read_a: assert property (
    rdu |=> sfr_rdata == udbg_pkg::UNMAPPED_READ)
    else $error("unmapped read not zero");
  mode_readback_a: assert property (
    wrc && !sfr_rmw ##1 rdc && !sfr_wr
    |=> sfr_rdata[7:6] == $past(sfr_wdata[7:6], 2))
    else $error("mode bits not read back");
  ctrl_readback_a: assert property (
    wrc && !sfr_rmw ##1 rdc && !sfr_wr
    |=> sfr_rdata[5:3] == $past(sfr_wdata[5:3], 2))
    else $error("firmware control bits not read back");
  flags_sticky_a: assert property (
    rdc && !sfr_wr |=> (sfr_rdata[1:0] & $past(seen_q)) == $past(seen_q))
    else $error("done flag dropped without a write");
  shift_oe_mode_a: assert property (
    rx_pin_oe |-> mode_q == udbg_pkg::MODE_SHIFT)
    else $error("data pin driven outside shift mode");
  shift_drive_a: assert property (
    $rose(rx_pin_oe) |-> rx_pin_oe [*8])
    else $error("shift transmit drive too short");
  start_bit_len_a: assert property (
    $fell(tx_pin) && mode_q == udbg_pkg::MODE_9BIT_FIX |-> !tx_pin [*8])
    else $error("serial low level shorter than a bit");

  tx_flag_c: cover property (rdc ##1 sfr_rdata[udbg_pkg::TXF_BIT]);
  rx_flag_c: cover property (rdc ##1 sfr_rdata[udbg_pkg::RXF_BIT]);
  shift_tx_c: cover property ($rose(rx_pin_oe));
endmodule

bind udbg_serial_ctrl udbg_serial_ctrl_chk udbg_serial_ctrl_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rmw(sfr_rmw),
  .sfr_rdata(sfr_rdata), .rate_double(rate_double),
  .ext_tick16(ext_tick16), .tx_pin(tx_pin), .rx_pin_i(rx_pin_i),
  .rx_pin_o(rx_pin_o), .rx_pin_oe(rx_pin_oe));
`default_nettype wire

// ===== udbg_peer.sv
// serial peer model: sends frames to the port and captures its output
// assumes bit times are given in ref_clk cycles
`timescale 1ns/1ps
`default_nettype none
module udbg_peer (
  input wire logic ref_clk,
  input wire logic line_in,
  output logic line_out
);
  // line rests at the stop level between frames
  initial line_out = 1'b1;

  // ==========
  // start bit, nb bits lsb first, then back to idle
  task automatic send(input logic [9:0] v, input int nb, input int bc);
    int i;
    @(negedge ref_clk);
    line_out = 1'b0;
    repeat (bc) @(negedge ref_clk);
    for (i = 0; i < nb; i++) begin
      line_out = v[i];
      repeat (bc) @(negedge ref_clk);
    end
    line_out = 1'b1;
  endtask

  // ==========
  // samples mid-bit; bounded wait so a silent port cannot hang
  task automatic catch_frame(input int nb, input int bc,
      output logic [8:0] v);
    int i;
    int n;
    n = 0;
    v = 9'h000;
    // falling edges only: the port's pin is settled there
    while (line_in !== 1'b0 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (bc / 2) @(negedge ref_clk);
    for (i = 0; i < nb; i++) begin
      repeat (bc) @(negedge ref_clk);
      v[i] = line_in;
    end
  endtask
endmodule
`default_nettype wire

// ===== udbg_serial_ctrl_bench.sv
// self-checking bench for the debug serial port control block
// assumes udbg_peer on the serial pins; bit time 32 clocks
`timescale 1ns/1ps
`default_nettype none
module udbg_serial_ctrl_bench;
  localparam logic [7:0] CA = udbg_pkg::CTRL_ADDR;
  localparam logic [7:0] DA = udbg_pkg::DATA_ADDR;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic sfr_rmw = 1'b0;
  logic rate_double = 1'b1;
  logic ext_tick16 = 1'b0;
  wire logic [7:0] sfr_rdata;
  wire logic tx_pin;
  wire logic rx_pin_o;
  wire logic rx_pin_oe;
  wire logic peer_line;
  wire logic rx_wire;
  int error_cnt = 0;
  int n_checks = 0;
  int i;
  logic [7:0] rd_val;
  logic [8:0] frame;
  logic [7:0] ctl [3];

  // ==========
  // clock, tick source, shared data pin
  always #5 ref_clk = ~ref_clk;
  // one-cycle pulse every two clocks gives a 32-clock bit
  always @(negedge ref_clk) ext_tick16 <= ~ext_tick16;
  assign rx_wire = rx_pin_oe ? rx_pin_o : peer_line;

  udbg_serial_ctrl udbg_serial_ctrl_inst (
    .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rmw(sfr_rmw),
    .sfr_rdata(sfr_rdata), .rate_double(rate_double),
    .ext_tick16(ext_tick16), .tx_pin(tx_pin), .rx_pin_i(rx_wire),
    .rx_pin_o(rx_pin_o), .rx_pin_oe(rx_pin_oe));
  udbg_peer udbg_peer_inst (
    .ref_clk(ref_clk), .line_in(tx_pin), .line_out(peer_line));

  // ==========
  // register access and checking
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
      input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rchk(input string what, input logic [7:0] a,
      input logic [7:0] m, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    rd_val = sfr_rdata;
    chk(what, e, rd_val & m);
    // idle cycle, so a following read never re-raises the strobe at once
    @(negedge ref_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========
  // watchdog, about five times the expected run
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("watchdog expired");
    finish_test();
  end

  // ==========
  // tests
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    rchk("ctrl reset", CA, 8'hFF, udbg_pkg::CTRL_RESET);
    rchk("data reset", DA, 8'hFF, udbg_pkg::DATA_RESET);
    rchk("unmapped", 8'h9A, 8'hFF, 8'h00);
    $display("test reset done");
    // mode 1 ignores the ninth-bit field, mode 3 sends a zero
    ctl = '{8'h48, 8'h88, 8'hC0};
    for (i = 0; i < 3; i++) begin
      wr(CA, ctl[i]);
      rchk("ctrl readback", CA, 8'hFC, ctl[i]);
      fork
        udbg_peer_inst.catch_frame(9, 32, frame);
        wr(DA, 8'h5A ^ 8'(i));
      join
      @(negedge ref_clk);
      chk("tx data", 8'h5A ^ 8'(i), frame[7:0]);
      chk("tx ninth", (i == 0) ? 8'h01 : {7'h0, ctl[i][3]},
        {7'h0, frame[8]});
      rchk("tx flag mid", CA, 8'h02, (i == 0) ? 8'h02 : 8'h00);
      repeat (30) @(negedge ref_clk);
      chk("tx stop", 8'h01, {7'h0, tx_pin});
      rchk("tx flag end", CA, 8'h02, 8'h02);
      repeat (20) @(negedge ref_clk);
    end
    $display("test transmit done");
    wr(CA, 8'hB0);
    udbg_peer_inst.send({2'b10, 8'h3C}, 10, 32);
    rchk("filtered flags", CA, 8'h05, 8'h00);
    rchk("filtered data", DA, 8'hFF, 8'h00);
    udbg_peer_inst.send({2'b11, 8'hC3}, 10, 32);
    rchk("rx flags", CA, 8'h05, 8'h05);
    rchk("rx data", DA, 8'hFF, 8'hC3);
    wr(CA, 8'h80);
    rchk("flags cleared", CA, 8'h07, 8'h00);
    udbg_peer_inst.send({2'b11, 8'h77}, 10, 32);
    rchk("rx off flag", CA, 8'h01, 8'h00);
    rchk("rx off data", DA, 8'hFF, 8'hC3);
    wr(CA, 8'h90);
    udbg_peer_inst.send({2'b10, 8'h21}, 10, 32);
    rchk("unfiltered flags", CA, 8'h05, 8'h01);
    // locked read-modify-write: a frame lands between read and write-back
    wr(CA, 8'h90);
    sfr_rmw = 1'b1;
    rchk("rmw read", CA, 8'h05, 8'h00);
    udbg_peer_inst.send({2'b11, 8'h44}, 10, 32);
    wr(CA, rd_val);
    sfr_rmw = 1'b0;
    rchk("rmw flags", CA, 8'h05, 8'h05);
    rchk("rmw data", DA, 8'hFF, 8'h44);
    $display("test receive 9-bit done");
    wr(CA, 8'h70);
    udbg_peer_inst.send({2'b00, 8'h96}, 9, 32);
    rchk("bad stop flags", CA, 8'h05, 8'h00);
    udbg_peer_inst.send({2'b01, 8'h96}, 9, 32);
    rchk("stop flags", CA, 8'h05, 8'h05);
    rchk("stop data", DA, 8'hFF, 8'h96);
    $display("test receive 8-bit done");
    wr(CA, 8'h10);
    // flag lands the fixed delay after the edge that starts the engine
    repeat (udbg_pkg::M0_RXF_CLKS) @(negedge ref_clk);
    rchk("shift rx early", CA, 8'h01, 8'h00);
    rchk("shift rx flag", CA, 8'h05, 8'h01);
    rchk("shift rx data", DA, 8'hFF, 8'hFF);
    wr(DA, 8'hA5);
    repeat (30) @(negedge ref_clk);
    rchk("shift tx mid", CA, 8'h02, 8'h00);
    repeat (30) @(negedge ref_clk);
    rchk("shift tx flag", CA, 8'h02, 8'h02);
    $display("test shift mode done");
    finish_test();
  end
endmodule
`default_nettype wire
